// File: pkg/sdrdev_pkg.sv
// Purpose: shared constants and types for the synchronous dram device model
// Assumes: 40 MHz system clock, apb register access
// Notes:   command codes are {row strobe, column strobe, write enable}, active low
package sdrdev_pkg;

  localparam int unsigned CLK_FREQ_HZ     = 40_000_000;
  localparam int unsigned INIT_WAIT_US    = 100;
  localparam int unsigned INIT_WAIT_CYC   = (INIT_WAIT_US * (CLK_FREQ_HZ / 1_000_000));
  localparam int unsigned WAIT_CNT_W      = 13;

  localparam int unsigned ADDR_W          = 12;
  localparam int unsigned DATA_W          = 16;
  localparam int unsigned COL_W           = 10;
  localparam int unsigned NUM_BANKS       = 4;
  localparam int unsigned ROWS_PER_BANK   = 4096;
  localparam int unsigned ROW_KEEP_W      = 2;
  localparam int unsigned MEM_IDX_W       = 2 + ROW_KEEP_W + COL_W;
  localparam int unsigned MEM_WORDS       = 1 << MEM_IDX_W;

  localparam int unsigned AP_BIT          = 10;

  // organisation codes held in the control register
  localparam logic [1:0] ORG_X16          = 2'h0;
  localparam logic [1:0] ORG_X8           = 2'h1;
  localparam logic [1:0] ORG_X4           = 2'h2;
  localparam logic [9:0] COLMASK_X16      = 10'h0FF;
  localparam logic [9:0] COLMASK_X8       = 10'h1FF;
  localparam logic [9:0] COLMASK_X4       = 10'h3FF;
  localparam logic [15:0] DMASK_X16       = 16'hFFFF;
  localparam logic [15:0] DMASK_X8        = 16'h00FF;
  localparam logic [15:0] DMASK_X4        = 16'h000F;

  // mode register fields
  localparam int unsigned MR_BL_LSB       = 0;
  localparam int unsigned MR_BT_BIT       = 3;
  localparam int unsigned MR_CL_LSB       = 4;
  localparam int unsigned MR_WB_BIT       = 9;
  localparam logic [2:0] BL_1             = 3'h0;
  localparam logic [2:0] BL_2             = 3'h1;
  localparam logic [2:0] BL_4             = 3'h2;
  localparam logic [2:0] BL_8             = 3'h3;
  localparam logic [2:0] BL_PAGE          = 3'h7;
  localparam logic [2:0] CL_3             = 3'h3;
  localparam logic [11:0] MODE_RST        = 12'h000;

  typedef enum logic [2:0] {
    SDRDEV_CMD_LMR  = 3'h0,
    SDRDEV_CMD_REF  = 3'h1,
    SDRDEV_CMD_PRE  = 3'h2,
    SDRDEV_CMD_ACT  = 3'h3,
    SDRDEV_CMD_WR   = 3'h4,
    SDRDEV_CMD_RD   = 3'h5,
    SDRDEV_CMD_BST  = 3'h6,
    SDRDEV_CMD_NOP  = 3'h7
  } sdrdev_cmd_t;

  typedef enum logic [1:0] {
    SDRDEV_ST_WAIT  = 2'h0,
    SDRDEV_ST_TIMED = 2'h1,
    SDRDEV_ST_IDLE  = 2'h3,
    SDRDEV_ST_READY = 2'h2
  } sdrdev_init_t;

  // apb map
  localparam logic [11:0] REG_CTRL        = 12'h000;
  localparam logic [11:0] REG_STATUS      = 12'h004;
  localparam logic [11:0] REG_MODE        = 12'h008;
  localparam logic [11:0] REG_BANKS       = 12'h00C;
  localparam int unsigned CTRL_CLR_BIT    = 8;
  localparam logic [1:0] CTRL_ORG_RST     = ORG_X16;
  localparam int unsigned ERR_W           = 4;
  localparam int unsigned ERR_EARLY       = 0;
  localparam int unsigned ERR_CLOSED      = 1;
  localparam int unsigned ERR_NOMODE      = 2;
  localparam int unsigned ERR_LMR         = 3;
  localparam logic [3:0] REF_MAX          = 4'hF;

endpackage : sdrdev_pkg

// File: pkg/sdrdev_bank_if.sv
// Purpose: command carrier from the decoder to the bank trackers
// Assumes: one-cycle command pulses, already qualified by chip select
// Notes:   per-bank state returns on plain ports
interface sdrdev_bank_if;
  logic        act;
  logic        pre;
  logic        pre_all;
  logic [1:0]  bank;
  logic [11:0] row;
  logic        ap_close;
  logic [1:0]  ap_bank;

  modport ctrl (output act, output pre, output pre_all, output bank, output row,
                output ap_close, output ap_bank);
  modport bank_end (input act, input pre, input pre_all, input bank, input row,
                    input ap_close, input ap_bank);
endinterface : sdrdev_bank_if

// File: logic/sdrdev_bank.sv
// Purpose: open/closed state and open row of one bank
// Assumes: reset already synchronised
// Notes:   activate on an open bank simply reloads the row
module sdrdev_bank #(
  parameter logic [1:0] IDX = 2'h0
) (
  input  wire logic  clk_sys,
  input  wire logic  rst_sync_n,
  sdrdev_bank_if.bank_end cmd,
  output logic       row_open,
  output logic [11:0] open_row
);

  wire logic hit = (cmd.bank == IDX);

  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      row_open <= 1'b0;
    end else if (cmd.act && hit) begin
      row_open <= 1'b1;
    end else if ((cmd.pre && (cmd.pre_all || hit)) || (cmd.ap_close && cmd.ap_bank == IDX)) begin
      row_open <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      open_row <= 12'h000;
    end else if (cmd.act && hit) begin
      open_row <= cmd.row;
    end
  end

endmodule : sdrdev_bank

// File: logic/sdrdev_top.sv
// Purpose: synchronous dram device: command decode, banks, bursts, init tracking
// Assumes: pins synchronous to clk_sys; apb slave for status and organisation
// Notes:   storage keeps only two row bits per bank, so rows alias
// Notes on behaviour
// - two bank-select inputs pick the bank for activate, read, write, precharge
// - activate takes all twelve address inputs as the row
// - column comes from ten, nine or eight low address bits per organisation
// - address bit ten on read or write requests automatic precharge at burst end
// - precharge with bit ten high closes all banks, else only the selected
// - load mode register stores the address inputs as op-code
// - data bus is sixteen, eight or four bits, upper lines unused
// - four banks of 4096 rows with 1024, 512 or 256 columns
// - every input is registered on the rising clock edge
// - bursts start at registered column and run programmed length and order
// - precharge-all after the wait, then only no-op for row precharge time
// - mode register loaded with bank selects zero before operational commands
// - data outputs go high impedance once mode register load is issued
// - mode register holds its value until loaded again
// - commands ignored while chip select high, running bursts complete
module sdrdev_top (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        clk_gate,
  input  wire logic        chip_sel_n,
  input  wire logic        row_strobe_n,
  input  wire logic        col_strobe_n,
  input  wire logic        write_en_n,
  input  wire logic        bank_sel_lo,
  input  wire logic        bank_sel_hi,
  input  wire logic [11:0] addr_in,
  input  wire logic        dq_mask,
  input  wire logic [15:0] data_lines_in,
  output logic      [15:0] data_lines_out,
  output logic             data_lines_oe,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr
);

  logic [1:0]  rst_pipe;
  logic        rst_sync_n;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_sync_n = rst_pipe[1];

  // command decode; clock-gate low forces no-op and holds bursts and read data, the init wait still counts
  sdrdev_pkg::sdrdev_cmd_t cmd;
  logic [1:0]  bank_in;
  logic        cmd_live;
  assign bank_in  = {bank_sel_hi, bank_sel_lo};
  assign cmd_live = clk_gate && !chip_sel_n;
  assign cmd      = cmd_live ? sdrdev_pkg::sdrdev_cmd_t'({row_strobe_n, col_strobe_n, write_en_n})
                             : sdrdev_pkg::SDRDEV_CMD_NOP;

  logic [11:0] mode_reg;
  logic [1:0]  org_reg;
  logic [9:0]  col_mask;
  logic [15:0] dmask;
  always_comb begin
    unique case (org_reg)
      sdrdev_pkg::ORG_X8: begin
        col_mask = sdrdev_pkg::COLMASK_X8;
        dmask    = sdrdev_pkg::DMASK_X8;
      end
      sdrdev_pkg::ORG_X4: begin
        col_mask = sdrdev_pkg::COLMASK_X4;
        dmask    = sdrdev_pkg::DMASK_X4;
      end
      default: begin
        col_mask = sdrdev_pkg::COLMASK_X16;
        dmask    = sdrdev_pkg::DMASK_X16;
      end
    endcase
  end

  // bank trackers
  sdrdev_bank_if bif ();
  logic [3:0]  bank_open;
  logic [11:0] bank_row [4];
  logic        burst_end;
  logic        burst_ap_reg;
  logic [1:0]  burst_bank_reg;
  assign bif.act      = (cmd == sdrdev_pkg::SDRDEV_CMD_ACT);
  assign bif.pre      = (cmd == sdrdev_pkg::SDRDEV_CMD_PRE);
  assign bif.pre_all  = addr_in[sdrdev_pkg::AP_BIT];
  assign bif.bank     = bank_in;
  assign bif.row      = addr_in;
  for (genvar b = 0; b < sdrdev_pkg::NUM_BANKS; b++) begin : g_bank
    sdrdev_bank #(.IDX(2'(b))) u_bank (
      .clk_sys    (clk_sys),
      .rst_sync_n (rst_sync_n),
      .cmd        (bif.bank_end),
      .row_open   (bank_open[b]),
      .open_row   (bank_row[b])
    );
  end

  // burst engine
  logic        is_rw;
  logic        burst_act_reg;
  logic        burst_wr_reg;
  logic [9:0]  burst_start_reg;
  logic [9:0]  burst_cnt_reg;
  logic [9:0]  burst_last_reg;
  logic [11:0] burst_row_reg;
  logic [9:0]  bl_last;
  logic        acc_valid;
  logic        acc_wr;
  logic [1:0]  acc_bank;
  logic [11:0] acc_row;
  logic [9:0]  acc_start;
  logic [9:0]  acc_cnt;
  logic [9:0]  acc_last;
  logic [9:0]  acc_col;
  logic        acc_ap;
  assign is_rw = (cmd == sdrdev_pkg::SDRDEV_CMD_RD) || (cmd == sdrdev_pkg::SDRDEV_CMD_WR);

  always_comb begin
    unique case (mode_reg[sdrdev_pkg::MR_BL_LSB +: 3])
      sdrdev_pkg::BL_2:    bl_last = 10'h001;
      sdrdev_pkg::BL_4:    bl_last = 10'h003;
      sdrdev_pkg::BL_8:    bl_last = 10'h007;
      sdrdev_pkg::BL_PAGE: bl_last = col_mask;
      default:             bl_last = 10'h000;
    endcase
    // single-location writes when write burst mode bit is set
    if ((cmd == sdrdev_pkg::SDRDEV_CMD_WR) && mode_reg[sdrdev_pkg::MR_WB_BIT]) begin
      bl_last = 10'h000;
    end
  end

  always_comb begin
    if (is_rw && clk_gate) begin
      acc_valid = bank_open[bank_in];
      acc_wr    = (cmd == sdrdev_pkg::SDRDEV_CMD_WR);
      acc_bank  = bank_in;
      acc_row   = bank_row[bank_in];
      acc_start = addr_in[9:0] & col_mask;
      acc_cnt   = 10'h000;
      acc_last  = bl_last;
      acc_ap    = addr_in[sdrdev_pkg::AP_BIT];
    end else begin
      acc_valid = burst_act_reg && clk_gate;
      acc_wr    = burst_wr_reg;
      acc_bank  = burst_bank_reg;
      acc_row   = burst_row_reg;
      acc_start = burst_start_reg;
      acc_cnt   = burst_cnt_reg;
      acc_last  = burst_last_reg;
      acc_ap    = burst_ap_reg;
    end
    // wrap inside the block; interleaved order xors the offset in
    if (mode_reg[sdrdev_pkg::MR_BT_BIT] && (acc_last != col_mask)) begin
      acc_col = (acc_start & ~acc_last) | ((acc_start ^ acc_cnt) & acc_last);
    end else begin
      acc_col = (acc_start & ~acc_last) | (10'(acc_start + acc_cnt) & acc_last);
    end
  end
  assign burst_end = acc_valid && (acc_cnt == acc_last);
  // flag of the live access, so a single beat closes its bank too
  assign bif.ap_close = burst_end && acc_ap;
  assign bif.ap_bank  = acc_bank;

  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      burst_act_reg <= 1'b0;
    end else if (cmd == sdrdev_pkg::SDRDEV_CMD_BST) begin
      burst_act_reg <= 1'b0;
    end else if (acc_valid) begin
      burst_act_reg <= !burst_end;
    end else if (is_rw) begin
      burst_act_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      burst_wr_reg    <= 1'b0;
      burst_ap_reg    <= 1'b0;
      burst_bank_reg  <= 2'h0;
      burst_row_reg   <= 12'h000;
      burst_start_reg <= 10'h000;
      burst_cnt_reg   <= 10'h000;
      burst_last_reg  <= 10'h000;
    end else if (acc_valid) begin
      burst_ap_reg    <= acc_ap;
      burst_wr_reg    <= acc_wr;
      burst_bank_reg  <= acc_bank;
      burst_row_reg   <= acc_row;
      burst_start_reg <= acc_start;
      burst_cnt_reg   <= 10'(acc_cnt + 10'h001);
      burst_last_reg  <= acc_last;
    end
  end

  // storage: aliasing of upper row bits trades capacity for simulation memory
  logic [15:0] mem [sdrdev_pkg::MEM_WORDS];
  logic [sdrdev_pkg::MEM_IDX_W-1:0] acc_idx;
  assign acc_idx = {acc_bank, acc_row[sdrdev_pkg::ROW_KEEP_W-1:0], acc_col};
  always_ff @(posedge clk_sys) begin
    if (acc_valid && acc_wr && !dq_mask) begin
      mem[acc_idx] <= data_lines_in & dmask;
    end
  end

  // read latency pipeline, taps chosen by cas latency
  logic        rp1_v_reg;
  logic        rp2_v_reg;
  logic [15:0] rp1_d_reg;
  logic [15:0] rp2_d_reg;
  logic        lmr_now;
  assign lmr_now = (cmd == sdrdev_pkg::SDRDEV_CMD_LMR);
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rp1_v_reg <= 1'b0;
      rp2_v_reg <= 1'b0;
      rp1_d_reg <= 16'h0000;
      rp2_d_reg <= 16'h0000;
    end else if (lmr_now) begin
      rp1_v_reg <= 1'b0;
      rp2_v_reg <= 1'b0;
    end else if (clk_gate) begin
      rp1_v_reg <= acc_valid && !acc_wr && !dq_mask;
      rp1_d_reg <= mem[acc_idx] & dmask;
      rp2_v_reg <= rp1_v_reg;
      rp2_d_reg <= rp1_d_reg;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      data_lines_oe  <= 1'b0;
      data_lines_out <= 16'h0000;
    end else if (lmr_now) begin
      data_lines_oe  <= 1'b0;
    end else if (clk_gate) begin
      if (mode_reg[sdrdev_pkg::MR_CL_LSB +: 3] == sdrdev_pkg::CL_3) begin
        data_lines_oe  <= rp2_v_reg;
        data_lines_out <= rp2_d_reg;
      end else begin
        data_lines_oe  <= rp1_v_reg;
        data_lines_out <= rp1_d_reg;
      end
    end
  end

  // mode register keeps its contents until the next load
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      mode_reg <= sdrdev_pkg::MODE_RST;
    end else if (lmr_now) begin
      mode_reg <= addr_in;
    end
  end

  // init tracking
  sdrdev_pkg::sdrdev_init_t init_reg;
  logic [sdrdev_pkg::WAIT_CNT_W-1:0] wait_cnt_reg;
  logic        wait_done;
  logic        mode_ok_reg;
  logic [3:0]  ref_cnt_reg;
  assign wait_done = (wait_cnt_reg == sdrdev_pkg::WAIT_CNT_W'(sdrdev_pkg::INIT_WAIT_CYC));

  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      wait_cnt_reg <= '0;
    end else if (!wait_done) begin
      wait_cnt_reg <= wait_cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      init_reg <= sdrdev_pkg::SDRDEV_ST_WAIT;
    end else begin
      unique case (init_reg)
        sdrdev_pkg::SDRDEV_ST_WAIT:  if (wait_done) init_reg <= sdrdev_pkg::SDRDEV_ST_TIMED;
        sdrdev_pkg::SDRDEV_ST_TIMED: if (bif.pre && bif.pre_all) init_reg <= sdrdev_pkg::SDRDEV_ST_IDLE;
        sdrdev_pkg::SDRDEV_ST_IDLE:  if (lmr_now && ref_cnt_reg >= 4'h2) init_reg <= sdrdev_pkg::SDRDEV_ST_READY;
        sdrdev_pkg::SDRDEV_ST_READY: init_reg <= sdrdev_pkg::SDRDEV_ST_READY;
      endcase
    end
  end

  // refreshes must come before the mode load; ready needs two of them counted by then
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ref_cnt_reg <= 4'h0;
    end else if (cmd == sdrdev_pkg::SDRDEV_CMD_REF && ref_cnt_reg != sdrdev_pkg::REF_MAX) begin
      ref_cnt_reg <= ref_cnt_reg + 4'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      mode_ok_reg <= 1'b0;
    end else if (lmr_now) begin
      mode_ok_reg <= 1'b1;
    end
  end

  // sticky protocol errors; a new error beats a clear in the same cycle
  logic [sdrdev_pkg::ERR_W-1:0] err_reg;
  logic [sdrdev_pkg::ERR_W-1:0] err_set;
  logic        apb_wr;
  logic        err_clr;
  always_comb begin
    err_set = '0;
    err_set[sdrdev_pkg::ERR_EARLY]  = !wait_done && cmd != sdrdev_pkg::SDRDEV_CMD_NOP;
    err_set[sdrdev_pkg::ERR_CLOSED] = is_rw && clk_gate && !bank_open[bank_in];
    err_set[sdrdev_pkg::ERR_NOMODE] = !mode_ok_reg && (is_rw || bif.act);
    err_set[sdrdev_pkg::ERR_LMR]    = lmr_now && (bank_in != 2'h0 || bank_open != 4'h0);
  end
  assign err_clr = apb_wr && paddr == sdrdev_pkg::REG_CTRL && pwdata[sdrdev_pkg::CTRL_CLR_BIT];
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      err_reg <= '0;
    end else begin
      err_reg <= (err_clr ? '0 : err_reg) | err_set;
    end
  end

  // apb slave: one wait state, ready and data come from flops
  logic        apb_hit;
  logic [31:0] rd_next;
  logic        map_ok;
  assign apb_hit = psel && penable && !pready;
  assign apb_wr  = psel && penable && pready && pwrite;
  always_comb begin
    map_ok  = 1'b1;
    rd_next = 32'h0000_0000;
    unique case (paddr)
      sdrdev_pkg::REG_CTRL:   rd_next = {30'h0, org_reg};
      sdrdev_pkg::REG_STATUS: rd_next = {16'h0, ref_cnt_reg, 4'(err_reg), 3'h0, mode_ok_reg,
                                         wait_done, 1'b0, 2'(init_reg)};
      sdrdev_pkg::REG_MODE:   rd_next = {20'h0, mode_reg};
      sdrdev_pkg::REG_BANKS:  rd_next = {28'h0, bank_open};
      default:                map_ok  = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= apb_hit;
      pslverr <= apb_hit && !map_ok;
      prdata  <= (apb_hit && !pwrite) ? rd_next : 32'h0000_0000;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      org_reg <= sdrdev_pkg::CTRL_ORG_RST;
    end else if (apb_wr && paddr == sdrdev_pkg::REG_CTRL) begin
      org_reg <= pwdata[1:0];
    end
  end

endmodule : sdrdev_top

// File: tb/sdrdev_checker.sv
// Purpose: port-level assertions for the dram device
// Assumes: mode shadowed from load commands seen at the pins
// Notes:   apb answers judged against the fixed map
module sdrdev_checker (
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic        clk_gate,
  input wire logic        chip_sel_n,
  input wire logic        row_strobe_n,
  input wire logic        col_strobe_n,
  input wire logic        write_en_n,
  input wire logic [11:0] addr_in,
  input wire logic        data_lines_oe,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr
);
  timeunit 1ns / 1ps;
  logic [2:0]  cmd;
  logic        rd;
  logic        lmr;
  logic        cl3;
  logic        bl1;
  logic        mapped;
  logic [11:0] mode_reg;
  assign cmd    = {row_strobe_n, col_strobe_n, write_en_n};
  assign rd     = clk_gate && !chip_sel_n && (cmd == sdrdev_pkg::SDRDEV_CMD_RD);
  assign lmr    = clk_gate && !chip_sel_n && (cmd == sdrdev_pkg::SDRDEV_CMD_LMR);
  assign cl3    = (mode_reg[6:4] == sdrdev_pkg::CL_3);
  assign bl1    = (mode_reg[2:0] == sdrdev_pkg::BL_1);
  assign mapped = (paddr[11:4] == 8'h00) && (paddr[1:0] == 2'h0);
  // latency depends on the loaded mode, so keep a shadow
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg <= sdrdev_pkg::MODE_RST;
    end else if (lmr) begin
      mode_reg <= addr_in;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_lmr_quiets_bus: assert property (lmr |=> !data_lines_oe [*2])
    else $error("data bus driven after mode load");
  a_first_beat: assert property ($rose(data_lines_oe) |-> (cl3 ? $past(rd, 3) : $past(rd, 2)))
    else $error("read beat without read at latency");
  a_single_beat: assert property (data_lines_oe && bl1 |-> (cl3 ? $past(rd, 3) : $past(rd, 2)))
    else $error("extra beat in single burst");
  a_ready_next: assert property (psel && penable && !pready |=> pready)
    else $error("apb answer late");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("apb ready held");
  a_ready_access: assert property (pready |-> psel && penable)
    else $error("apb ready outside access");
  a_err_unmapped: assert property (pready |-> (pslverr == !mapped))
    else $error("apb error flag wrong");
  a_err_reads_zero: assert property (pready && pslverr |-> prdata == 32'h00000000)
    else $error("refused read not zero");
endmodule : sdrdev_checker
bind sdrdev_top sdrdev_checker u_chk (.clk_sys, .rst_n, .clk_gate, .chip_sel_n, .row_strobe_n, .col_strobe_n,
  .write_en_n, .addr_in, .data_lines_oe, .psel, .penable, .paddr, .prdata, .pready, .pslverr);

// File: tb/sdrdev_ctrl_model.sv
// Purpose: memory controller driving the device command pins
// Assumes: tasks entered just after a rising edge
// Notes:   delays rounded up to whole cycles
module sdrdev_ctrl_model #(
  parameter int CLK_NS      = 25,
  parameter int PRECHG_NS   = 20,
  parameter int REFRESH_NS  = 70,
  parameter int MODESET_NS  = 15,
  parameter int INIT_NS     = 100_000
) (
  input  wire logic        clk_sys,
  output logic             clk_gate,
  output logic             chip_sel_n,
  output logic             row_strobe_n,
  output logic             col_strobe_n,
  output logic             write_en_n,
  output logic             bank_sel_lo,
  output logic             bank_sel_hi,
  output logic [11:0]      addr_in,
  output logic             dq_mask,
  output logic [15:0]      data_lines_in
);
  timeunit 1ns / 1ps;
  localparam int PRE_CYC  = (PRECHG_NS + CLK_NS - 1) / CLK_NS;
  localparam int REF_CYC  = (REFRESH_NS + CLK_NS - 1) / CLK_NS;
  localparam int MRS_CYC  = (MODESET_NS + CLK_NS - 1) / CLK_NS;
  localparam int INIT_CYC = (INIT_NS + CLK_NS - 1) / CLK_NS;
  logic desel;
  initial begin
    clk_gate = 1'b0;
    chip_sel_n = 1'b1;
    {row_strobe_n, col_strobe_n, write_en_n} = 3'h7;
    {bank_sel_hi, bank_sel_lo} = 2'h0;
    addr_in = 12'h000;
    dq_mask = 1'b0;
    data_lines_in = 16'h0000;
    desel = 1'b0;
  end
  // one command, then n no-ops; n must be at least one
  task automatic cmd(input logic [2:0] c, input logic [1:0] b, input logic [11:0] a,
                     input logic [15:0] d, input int n);
    chip_sel_n <= desel;
    {row_strobe_n, col_strobe_n, write_en_n} <= c;
    {bank_sel_hi, bank_sel_lo} <= b;
    addr_in <= a;
    data_lines_in <= d;
    @(posedge clk_sys);
    {row_strobe_n, col_strobe_n, write_en_n} <= 3'h7;
    data_lines_in <= ~d;
    repeat (n) @(posedge clk_sys);
  endtask : cmd
  task automatic power_up(input logic early, input logic [11:0] mode);
    repeat (8) @(posedge clk_sys);
    clk_gate <= 1'b1;
    chip_sel_n <= 1'b0;
    repeat (8) @(posedge clk_sys);
    if (early) begin
      cmd(sdrdev_pkg::SDRDEV_CMD_ACT, 2'h2, 12'h000, 16'h0000, 1);
    end
    repeat (INIT_CYC) @(posedge clk_sys);
    cmd(sdrdev_pkg::SDRDEV_CMD_PRE, 2'h0, 12'h400, 16'h0000, PRE_CYC);
    repeat (2) cmd(sdrdev_pkg::SDRDEV_CMD_REF, 2'h0, 12'h000, 16'h0000, REF_CYC);
    cmd(sdrdev_pkg::SDRDEV_CMD_LMR, 2'h0, mode, 16'h0000, MRS_CYC);
  endtask : power_up
endmodule : sdrdev_ctrl_model

// File: tb/sdrdev_top_tb_top.sv
// Purpose: self-checking bench for the dram device
// Assumes: single beat bursts, latency two
// Notes:   read data sampled at the edge, before flops update
module sdrdev_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys = 1'b0;
  logic        rst_n   = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h00000000;
  logic        clk_gate, chip_sel_n, row_strobe_n, col_strobe_n, write_en_n;
  logic        bank_sel_lo, bank_sel_hi, dq_mask, data_lines_oe, pready, pslverr, err;
  logic [11:0] addr_in;
  logic [15:0] data_lines_in, data_lines_out;
  logic [31:0] prdata, rdv;
  int          failures = 0;
  int          n_compared = 0;
  always #12.5 clk_sys = ~clk_sys;
  sdrdev_top dut (.clk_sys, .rst_n, .clk_gate, .chip_sel_n, .row_strobe_n, .col_strobe_n, .write_en_n,
    .bank_sel_lo, .bank_sel_hi, .addr_in, .dq_mask, .data_lines_in, .data_lines_out, .data_lines_oe,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
  sdrdev_ctrl_model u_ctl (.clk_sys, .clk_gate, .chip_sel_n, .row_strobe_n, .col_strobe_n, .write_en_n,
    .bank_sel_lo, .bank_sel_hi, .addr_in, .dq_mask, .data_lines_in);
  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : finish_test
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    // no cycle count assumed; the watchdog ends a hang
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rdv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apb
  task automatic reg_is(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h00000000);
    check(rdv & m, e);
  endtask : reg_is
  task automatic act(input logic [1:0] b, input logic [11:0] row);
    u_ctl.cmd(sdrdev_pkg::SDRDEV_CMD_ACT, b, row, 16'h0000, 1);
  endtask : act
  task automatic wr(input logic [1:0] b, input logic [11:0] a, input logic [15:0] d);
    u_ctl.cmd(sdrdev_pkg::SDRDEV_CMD_WR, b, a, d, 2);
  endtask : wr
  // sentinel stays when no beat appears
  task automatic rd(input logic [1:0] b, input logic [11:0] a, output logic [15:0] d);
    u_ctl.cmd(sdrdev_pkg::SDRDEV_CMD_RD, b, a, 16'h0000, 1);
    d = 16'hDEAD;
    repeat (6) begin
      @(posedge clk_sys);
      if (data_lines_oe === 1'b1 && d === 16'hDEAD) d = data_lines_out;
    end
  endtask : rd
  task automatic t_init;
    u_ctl.power_up(1'b1, 12'h020);
    reg_is(sdrdev_pkg::REG_STATUS, 32'h0000F11B, 32'h0000211A);
    reg_is(sdrdev_pkg::REG_BANKS, 32'h0000000F, 32'h00000000);
    apb(1'b1, sdrdev_pkg::REG_CTRL, 32'h00000100);
    reg_is(sdrdev_pkg::REG_STATUS, 32'h00000F00, 32'h00000000);
    reg_is(sdrdev_pkg::REG_MODE, 32'h00000FFF, 32'h00000020);
    $display("init test done");
  endtask : t_init
  task automatic t_banks;
    logic [15:0] d;
    for (int b = 0; b < 4; b++) begin
      act(2'(b), 12'hA00 | 12'(b));
      wr(2'(b), 12'(b * 3), 16'h1230 + 16'(b));
    end
    reg_is(sdrdev_pkg::REG_BANKS, 32'h0000000F, 32'h0000000F);
    for (int b = 0; b < 4; b++) begin
      rd(2'(b), 12'(b * 3), d);
      check(32'(d), 32'h00001230 + 32'(b));
    end
    u_ctl.cmd(sdrdev_pkg::SDRDEV_CMD_PRE, 2'h1, 12'h000, 16'h0000, 1);
    reg_is(sdrdev_pkg::REG_BANKS, 32'h0000000F, 32'h0000000D);
    wr(2'h0, 12'h407, 16'h5A5A);
    reg_is(sdrdev_pkg::REG_BANKS, 32'h0000000F, 32'h0000000C);
    u_ctl.cmd(sdrdev_pkg::SDRDEV_CMD_PRE, 2'h0, 12'h400, 16'h0000, 1);
    reg_is(sdrdev_pkg::REG_BANKS, 32'h0000000F, 32'h00000000);
    $display("bank test done");
  endtask : t_banks
  task automatic t_refused;
    logic [15:0] d;
    rd(2'h1, 12'h003, d);
    check(32'(d), 32'h0000DEAD);
    reg_is(sdrdev_pkg::REG_STATUS, 32'h00000200, 32'h00000200);
    u_ctl.desel = 1'b1;
    act(2'h3, 12'h001);
    u_ctl.desel = 1'b0;
    reg_is(sdrdev_pkg::REG_BANKS, 32'h0000000F, 32'h00000000);
    apb(1'b0, 12'h010, 32'h00000000);
    check(32'(err), 32'h00000001);
    $display("refusal test done");
  endtask : t_refused
  task automatic t_org;
    logic [15:0] d;
    apb(1'b1, sdrdev_pkg::REG_CTRL, {30'h0, sdrdev_pkg::ORG_X8});
    act(2'h0, 12'h000);
    wr(2'h0, 12'h105, 16'hABCD);
    wr(2'h0, 12'h005, 16'h0011);
    rd(2'h0, 12'h105, d);
    check(32'(d), 32'h000000CD);
    apb(1'b1, sdrdev_pkg::REG_CTRL, {30'h0, sdrdev_pkg::ORG_X16});
    rd(2'h0, 12'h105, d);
    check(32'(d), 32'h00000011);
    apb(1'b1, sdrdev_pkg::REG_CTRL, {30'h0, sdrdev_pkg::ORG_X4});
    wr(2'h0, 12'h3FF, 16'hFFFF);
    rd(2'h0, 12'h3FF, d);
    check(32'(d), 32'h0000000F);
    $display("organisation test done");
  endtask : t_org
  initial begin
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    t_init;
    t_banks;
    t_refused;
    t_org;
    finish_test;
  end
  // run needs about 4200 cycles
  initial begin
    #500000;
    failures++;
    finish_test;
  end
endmodule : sdrdev_top_tb_top
